// [core/slp_defines.svh]
/*
 * register offsets, field positions, reset values and timing counts
 * for the status led pattern block.
 * assumes inclusion by bare name from core/ sources.
 */
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH

// ********************************
// register map
// ********************************
`define SLP_CMD_OFFSET 8'h00
`define SLP_STATUS_OFFSET 8'h04
`define SLP_CMD_RESET 11'h000

// ********************************
// command register fields
// ********************************
`define SLP_CMD_MODE_LSB 0
`define SLP_CMD_MODE_MSB 1
`define SLP_CMD_ALIGNED 2
`define SLP_CMD_SETUP_LSB 3
`define SLP_CMD_ACTIVE_LSB 5
`define SLP_CMD_ENABLE_LSB 7
`define SLP_CMD_LEDDIS_LSB 9

// ********************************
// status register fields
// ********************************
`define SLP_ST_INIT 0
`define SLP_ST_ERROR 1
`define SLP_ST_ADDR_LSB 2
`define SLP_ST_ADDR_BAD 5
`define SLP_ST_NET_EN 6
`define SLP_ST_SENSE_LSB 7

// ********************************
// responses and timing
// ********************************
`define SLP_RESP_OKAY 2'h0
`define SLP_RESP_SLVERR 2'h2
`define SLP_CLK_HZ 40000000
`define SLP_TICK_MS 125
`define SLP_TICK_CYCLES ((`SLP_CLK_HZ / 1000) * `SLP_TICK_MS)
`define SLP_PHASE_LAST 6'h2f
`define SLP_HALF_TRIPLE 6'h18

`endif

// [core/slp_led_pattern.sv]
/*
 * one bi-colour led: phase counter on the shared tick and pattern decode.
 * assumes tick is a one-cycle pulse every 125 ms from the top.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slp_defines.svh"

module slp_led_pattern (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire slp_pkg::slp_pat_t pattern,
	output logic red,
	output logic green
);

	// ********************************
	// phase tracking
	// ********************************
	slp_pkg::slp_pat_t prev;
	logic [5:0] phase;
	logic [5:0] p24;
	logic changed;

	assign changed = (pattern != prev);
	// 48 ticks covers both the 16 and 24 tick periods
	assign p24 = (phase >= `SLP_HALF_TRIPLE) ? phase - `SLP_HALF_TRIPLE : phase;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev <= slp_pkg::SLP_PAT_OFF;
			phase <= 6'h00;
		end else begin
			prev <= pattern;
			if (changed) begin
				phase <= 6'h00;
			end else if (tick) begin
				phase <= (phase == `SLP_PHASE_LAST) ? 6'h00 : phase + 6'h01;
			end
		end
	end

	// ********************************
	// decode, one tick is 125 ms
	// ********************************
	function automatic logic [1:0] decode(input slp_pkg::slp_pat_t p, input logic [5:0] ph, input logic [5:0] q);
		logic [1:0] rg;
		rg = 2'b00;
		unique case (p)
			slp_pkg::SLP_PAT_OFF: rg = 2'b00;
			slp_pkg::SLP_PAT_GREEN: rg = 2'b01;
			slp_pkg::SLP_PAT_RED: rg = 2'b10;
			slp_pkg::SLP_PAT_INIT_G2: rg = {1'b0, !ph[3] && !ph[1]};
			slp_pkg::SLP_PAT_CAL_R4: rg = {!ph[0], 1'b0};
			slp_pkg::SLP_PAT_CFG_R2: rg = {!ph[3] && !ph[1], 1'b0};
			slp_pkg::SLP_PAT_ALT_SLOW: rg = {ph[1], !ph[1]};
			slp_pkg::SLP_PAT_ALT_FAST: rg = {ph[0], !ph[0]};
			slp_pkg::SLP_PAT_SETUP_R3: rg = {(q < 6'h0c) && !q[1], 1'b0};
			slp_pkg::SLP_PAT_MEAS_G2: rg = {1'b0, !ph[1]};
			slp_pkg::SLP_PAT_SENSE_R2: rg = {!ph[1], 1'b0};
			default: rg = 2'b00;
		endcase
		return rg;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			red <= 1'b0;
			green <= 1'b0;
		end else begin
			{red, green} <= decode(pattern, changed ? 6'h00 : phase, changed ? 6'h00 : p24);
		end
	end

	// ********************************
	// checks
	// ********************************
	restart_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
		changed |=> phase == 6'h00)
		else $error("phase not restarted on pattern change");
	init_dark_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pattern == slp_pkg::SLP_PAT_INIT_G2) && !changed && phase[3] |=> !green && !red)
		else $error("init pattern lit in dark second");
	setup_dark_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pattern == slp_pkg::SLP_PAT_SETUP_R3) && !changed && (p24 >= 6'h0c) |=> !red)
		else $error("setup pattern lit in dark half");
	cal_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pattern == slp_pkg::SLP_PAT_CAL_R4) && !changed && !phase[0] |=> red && !green)
		else $error("calibration flash missing");

endmodule // slp_led_pattern

`default_nettype wire

// [core/slp_pkg.sv]
/*
 * types shared by the status led pattern block.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none

package slp_pkg;

	// ********************************
	// module modes and led patterns
	// ********************************
	typedef enum logic [1:0] {
		SLP_MODE_MEAS = 2'b00,
		SLP_MODE_CAL = 2'b01,
		SLP_MODE_CFG = 2'b10,
		SLP_MODE_ALIGN = 2'b11
	} slp_mode_t;

	typedef enum logic [3:0] {
		SLP_PAT_OFF = 4'b0000,
		SLP_PAT_GREEN = 4'b0001,
		SLP_PAT_RED = 4'b0010,
		SLP_PAT_INIT_G2 = 4'b0011,
		SLP_PAT_CAL_R4 = 4'b0100,
		SLP_PAT_CFG_R2 = 4'b0101,
		SLP_PAT_ALT_SLOW = 4'b0110,
		SLP_PAT_ALT_FAST = 4'b0111,
		SLP_PAT_SETUP_R3 = 4'b1000,
		SLP_PAT_MEAS_G2 = 4'b1001,
		SLP_PAT_SENSE_R2 = 4'b1010
	} slp_pat_t;

	// ********************************
	// bus and sense carriers
	// ********************************
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} slp_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} slp_axi_rsp_t;

	typedef struct packed {
		logic internal_fault;
		logic stack_comm_fault;
		logic slave_mode;
		logic reference_present;
		logic [1:0] sensor_fault;
		logic net_if_fitted;
	} slp_sense_t;

endpackage

`default_nettype wire

// [core/slp_status_led.sv]
/*
 * status led block: axi4-lite registers, stack address decode,
 * network interface gating and two bi-colour led pattern drivers.
 * assumes inputs synchronous to aclk and an axi4-lite master on req/rsp.
 */
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "slp_defines.svh"

module slp_status_led #(
	parameter int TICK_CYCLES = `SLP_TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire slp_pkg::slp_axi_req_t req,
	output slp_pkg::slp_axi_rsp_t rsp,
	input wire slp_pkg::slp_sense_t sense,
	input wire logic [4:0] addr_switch,
	output logic [1:0] led_red,
	output logic [1:0] led_green,
	output logic net_if_enable
);

	// ********************************
	// declarations
	// ********************************
	logic awready;
	logic wready;
	logic bvalid;
	logic [1:0] bresp;
	logic arready;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_do;
	logic cmd_write;
	logic [10:0] cmd;
	logic [10:0] next_cmd;
	logic initialized;
	logic [2:0] stack_addr;
	logic addr_bad;
	logic [22:0] tb_count;
	logic tick;
	logic module_err;
	slp_pkg::slp_mode_t mode;
	slp_pkg::slp_pat_t pat [2];
	logic [31:0] status_word;

	assign rsp = '{awready: awready, wready: wready, bresp: bresp, bvalid: bvalid,
		arready: arready, rdata: rdata, rresp: rresp, rvalid: rvalid};

	// ********************************
	// write channel
	// ********************************
	// address and data may come in either order; response waits for both
	assign wr_do = !awready && !wready && !bvalid;
	assign cmd_write = wr_do && (wr_addr == `SLP_CMD_OFFSET);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wr_addr <= 8'h00;
		end else if (req.awvalid && awready) begin
			awready <= 1'b0;
			wr_addr <= req.awaddr;
		end else if (bvalid && req.bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else if (req.wvalid && wready) begin
			wready <= 1'b0;
			wr_data <= req.wdata;
			wr_strb <= req.wstrb;
		end else if (bvalid && req.bready) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `SLP_RESP_OKAY;
		end else if (wr_do) begin
			bvalid <= 1'b1;
			bresp <= cmd_write ? `SLP_RESP_OKAY : `SLP_RESP_SLVERR;
		end else if (bvalid && req.bready) begin
			bvalid <= 1'b0;
		end
	end

	// ********************************
	// command register
	// ********************************
	always_comb begin
		next_cmd = cmd;
		if (wr_strb[0]) begin
			next_cmd[7:0] = wr_data[7:0];
		end
		if (wr_strb[1]) begin
			next_cmd[10:8] = wr_data[10:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd <= `SLP_CMD_RESET;
		end else if (cmd_write) begin
			cmd <= next_cmd;
		end
	end

	// any accepted command, even with all strobes low, ends initialized
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			initialized <= 1'b1;
		end else if (cmd_write) begin
			initialized <= 1'b0;
		end
	end

	assign mode = slp_pkg::slp_mode_t'(cmd[`SLP_CMD_MODE_MSB:`SLP_CMD_MODE_LSB]);

	// ********************************
	// read channel
	// ********************************
	// fault bits sit at 8:7, just above the network enable
	assign status_word = {21'h00_0000, 2'b00, cmd[`SLP_CMD_ENABLE_LSB +: 2] & sense.sensor_fault,
		net_if_enable, addr_bad, stack_addr, module_err, initialized};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `SLP_RESP_OKAY;
		end else if (req.arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			unique case (req.araddr)
				`SLP_CMD_OFFSET: begin
					rdata <= {21'h00_0000, cmd};
					rresp <= `SLP_RESP_OKAY;
				end
				`SLP_STATUS_OFFSET: begin
					rdata <= status_word;
					rresp <= `SLP_RESP_OKAY;
				end
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= `SLP_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && req.rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ********************************
	// stack address
	// ********************************
	// five switches give positions one to five, six modules in all
	function automatic logic [3:0] addr_decode(input logic [4:0] sw);
		logic [3:0] r;
		r = 4'h8;
		unique case (sw)
			5'h00: r = 4'h0;
			5'h01: r = 4'h1;
			5'h02: r = 4'h2;
			5'h04: r = 4'h3;
			5'h08: r = 4'h4;
			5'h10: r = 4'h5;
			default: r = 4'h8;
		endcase
		return r;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_addr <= 3'h0;
			addr_bad <= 1'b0;
		end else begin
			{addr_bad, stack_addr} <= addr_decode(addr_switch);
		end
	end

	// decode is taken straight from the switches so the gate lags them by one cycle, as stack_addr does
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			net_if_enable <= 1'b0;
		end else begin
			net_if_enable <= sense.net_if_fitted && (addr_switch == 5'h00);
		end
	end

	// ********************************
	// shared timebase
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tb_count <= 23'h00_0000;
			tick <= 1'b0;
		end else if (tb_count == 23'(TICK_CYCLES - 1)) begin
			tb_count <= 23'h00_0000;
			tick <= 1'b1;
		end else begin
			tb_count <= tb_count + 23'h00_0001;
			tick <= 1'b0;
		end
	end

	// ********************************
	// pattern selection
	// ********************************
	assign module_err = sense.internal_fault || sense.stack_comm_fault ||
		(sense.slave_mode && !sense.reference_present);

	// module-wide states win over channel states
	function automatic slp_pkg::slp_pat_t chan_pat(input logic err, input logic init,
		input slp_pkg::slp_mode_t md, input logic aligned, input logic dis, input logic en,
		input logic flt, input logic setup, input logic act);
		slp_pkg::slp_pat_t p;
		p = slp_pkg::SLP_PAT_OFF;
		if (err) begin
			p = slp_pkg::SLP_PAT_RED;
		end else if (init) begin
			p = slp_pkg::SLP_PAT_INIT_G2;
		end else if (md == slp_pkg::SLP_MODE_CAL) begin
			p = slp_pkg::SLP_PAT_CAL_R4;
		end else if (md == slp_pkg::SLP_MODE_CFG) begin
			p = slp_pkg::SLP_PAT_CFG_R2;
		end else if (md == slp_pkg::SLP_MODE_ALIGN) begin
			p = aligned ? slp_pkg::SLP_PAT_ALT_FAST : slp_pkg::SLP_PAT_ALT_SLOW;
		end else if (dis) begin
			p = slp_pkg::SLP_PAT_OFF;
		end else if (flt && en) begin
			p = slp_pkg::SLP_PAT_SENSE_R2;
		end else if (setup) begin
			p = slp_pkg::SLP_PAT_SETUP_R3;
		end else if (act) begin
			p = slp_pkg::SLP_PAT_GREEN;
		end else begin
			p = slp_pkg::SLP_PAT_MEAS_G2;
		end
		return p;
	endfunction

	// each channel sees only its own fault bit
	generate
		for (genvar i = 0; i < 2; i++) begin : g_chan
			assign pat[i] = chan_pat(module_err, initialized, mode, cmd[`SLP_CMD_ALIGNED],
				cmd[`SLP_CMD_LEDDIS_LSB + i], cmd[`SLP_CMD_ENABLE_LSB + i],
				sense.sensor_fault[i], cmd[`SLP_CMD_SETUP_LSB + i],
				cmd[`SLP_CMD_ACTIVE_LSB + i]);
			slp_led_pattern u_led (
				.aclk(aclk),
				.aresetn(aresetn),
				.tick(tick),
				.pattern(pat[i]),
				.red(led_red[i]),
				.green(led_green[i])
			);
		end
	endgenerate

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic chan0_meas;
	assign chan0_meas = !module_err && !initialized && (mode == slp_pkg::SLP_MODE_MEAS);

	err_red_a: assert property (module_err |=> led_red == 2'b11 && led_green == 2'b00)
		else $error("module fault not shown steady red");
	init_hold_a: assert property (initialized && !cmd_write |=> initialized)
		else $error("initialized left without a command");
	init_clear_a: assert property (cmd_write |=> !initialized ##1 !initialized)
		else $error("initialized not cleared by command");
	net_gate_a: assert property (sense.net_if_fitted && addr_switch != 5'h00 |=> !net_if_enable)
		else $error("network interface on at non-zero address");
	addr_onehot_a: assert property (addr_switch == 5'h04 |=> stack_addr == 3'h3 && !addr_bad)
		else $error("one-hot address decode wrong");
	led_off_a: assert property (chan0_meas && cmd[`SLP_CMD_LEDDIS_LSB] |=> !led_red[0] && !led_green[0])
		else $error("disabled led lit");
	own_fault_a: assert property (chan0_meas && !cmd[`SLP_CMD_LEDDIS_LSB] && !cmd[`SLP_CMD_SETUP_LSB]
		&& cmd[`SLP_CMD_ACTIVE_LSB] && !sense.sensor_fault[0] |=> led_green[0] && !led_red[0])
		else $error("channel not steady green while active");
	off_no_fault_a: assert property (chan0_meas && !cmd[`SLP_CMD_LEDDIS_LSB] && !cmd[`SLP_CMD_SETUP_LSB]
		&& cmd[`SLP_CMD_ACTIVE_LSB] && !cmd[`SLP_CMD_ENABLE_LSB] |=> !led_red[0])
		else $error("fault pattern on disabled channel");

	err_seen_c: cover property (module_err ##1 !module_err);
	cmd_seen_c: cover property (cmd_write ##[1:4] (bvalid && req.bready));
	align_fast_c: cover property (!initialized && mode == slp_pkg::SLP_MODE_ALIGN && cmd[`SLP_CMD_ALIGNED]);

endmodule // slp_status_led

`default_nettype wire

// [test/slp_led_model.sv]
/*
 * led model: watches the two bi-colour status leds, counts lit and change cycles.
 * assumes the leds settle between aclk edges; clear high restarts a window.
 */
`timescale 1ns/1ps
`default_nettype none

module slp_led_model (
	input wire logic aclk,
	input wire logic clear,
	input wire logic [1:0] red,
	input wire logic [1:0] green,
	output logic [1:0][8:0] red_cnt,
	output logic [1:0][8:0] green_cnt,
	output logic [1:0][8:0] chg_cnt
);
	// ********************************
	// window counters
	// ********************************
	// counting over a whole pattern period makes the result independent of start phase
	logic [1:0][1:0] prev;

	always_ff @(posedge aclk) begin
		for (int i = 0; i < 2; i++) begin
			prev[i] <= {red[i], green[i]};
			if (clear) begin
				red_cnt[i] <= '0;
				green_cnt[i] <= '0;
				chg_cnt[i] <= '0;
			end else begin
				red_cnt[i] <= red_cnt[i] + 9'(red[i]);
				green_cnt[i] <= green_cnt[i] + 9'(green[i]);
				chg_cnt[i] <= chg_cnt[i] + 9'({red[i], green[i]} != prev[i]);
			end
		end
	end
endmodule // slp_led_model

`default_nettype wire

// [test/tb_top.sv]
/*
 * tb_top: self-checking bench for the status led block, tick shortened to 4 cycles.
 * assumes slp_pkg, the design files and the led model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slp_defines.svh"

module tb_top;
	// ********************************
	// signals and instances
	// ********************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clear = 1'b1;
	slp_pkg::slp_axi_req_t req = '0;
	slp_pkg::slp_axi_rsp_t rsp;
	slp_pkg::slp_sense_t sense = 7'h01;
	logic [4:0] addr_switch = 5'h00;
	logic [1:0] led_red;
	logic [1:0] led_green;
	logic net_if_enable;
	logic [1:0][8:0] red_cnt;
	logic [1:0][8:0] green_cnt;
	logic [1:0][8:0] chg_cnt;
	logic [31:0] rd;
	logic [1:0] rs;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;

	always #12.5 aclk = ~aclk;

	slp_status_led #(.TICK_CYCLES(4)) uut (.aclk(aclk), .aresetn(aresetn), .req(req), .rsp(rsp),
		.sense(sense), .addr_switch(addr_switch), .led_red(led_red), .led_green(led_green),
		.net_if_enable(net_if_enable));
	slp_led_model leds (.aclk(aclk), .clear(clear), .red(led_red), .green(led_green),
		.red_cnt(red_cnt), .green_cnt(green_cnt), .chg_cnt(chg_cnt));

	// ********************************
	// shared tasks
	// ********************************
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// a hang in any handshake wait ends here
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (!aw && rsp.awready === 1'b1) begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready === 1'b1) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end while (!(aw && w));
		while (rsp.bvalid !== 1'b1) @(posedge aclk);
		rs = rsp.bresp;
		req.bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do @(posedge aclk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		while (rsp.rvalid !== 1'b1) @(posedge aclk);
		rd = rsp.rdata;
		rs = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	// one full pattern period: 48 ticks of 4 cycles
	task automatic measure;
		@(posedge aclk);
		clear <= 1'b1;
		repeat (4) @(posedge aclk);
		clear <= 1'b0;
		repeat (192) @(posedge aclk);
		#1;
	endtask

	task automatic led(input int ch, input int r, input int g, input int c);
		check(32'(red_cnt[ch]), 32'(r), "red cycles");
		check(32'(green_cnt[ch]), 32'(g), "green cycles");
		check(32'(chg_cnt[ch]), 32'(c), "colour changes");
	endtask

	task automatic both(input int r, input int g, input int c);
		led(0, r, g, c);
		led(1, r, g, c);
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_init;
		rdr(`SLP_STATUS_OFFSET);
		check(rd, 32'h0000_0041, "status after reset");
		check({31'h0, net_if_enable}, 32'h0000_0001, "net enable");
		measure;
		both(0, 48, 12);
		$display("t_init done");
	endtask

	task automatic t_error;
		logic [6:0] v[3] = '{7'h41, 7'h21, 7'h11};
		foreach (v[i]) begin
			sense <= v[i];
			measure;
			both(192, 0, 0);
		end
		sense <= 7'h19;
		measure;
		both(0, 48, 12);
		sense <= 7'h01;
		$display("t_error done");
	endtask

	task automatic t_modes;
		logic [10:0] c[4] = '{11'h001, 11'h002, 11'h003, 11'h007};
		int r[4] = '{96, 48, 96, 96};
		int g[4] = '{0, 0, 96, 96};
		int k[4] = '{48, 12, 24, 48};
		foreach (c[i]) begin
			wr(`SLP_CMD_OFFSET, 32'(c[i]));
			check(32'(rs), 32'(`SLP_RESP_OKAY), "bresp");
			measure;
			both(r[i], g[i], k[i]);
		end
		rdr(`SLP_STATUS_OFFSET);
		check(rd, 32'h0000_0040, "status after command");
		rdr(`SLP_CMD_OFFSET);
		check(rd, 32'h0000_0007, "cmd readback");
		$display("t_modes done");
	endtask

	task automatic t_chan;
		wr(`SLP_CMD_OFFSET, 32'h0000_0030);
		measure;
		led(0, 0, 192, 0);
		led(1, 48, 0, 12);
		wr(`SLP_CMD_OFFSET, 32'h0000_0000);
		measure;
		both(0, 96, 24);
		$display("t_chan done");
	endtask

	task automatic t_fault;
		sense <= 7'h03;
		wr(`SLP_CMD_OFFSET, 32'h0000_0180);
		measure;
		led(0, 96, 0, 24);
		led(1, 0, 96, 24);
		rdr(`SLP_STATUS_OFFSET);
		check(rd & 32'h0000_0180, 32'h0000_0080, "fault status");
		wr(`SLP_CMD_OFFSET, 32'h0000_0120);
		measure;
		led(0, 0, 192, 0);
		wr(`SLP_CMD_OFFSET, 32'h0000_03a0);
		measure;
		led(0, 0, 0, 0);
		led(1, 0, 96, 24);
		sense <= 7'h01;
		$display("t_fault done");
	endtask

	task automatic t_addr;
		for (int i = 0; i < 5; i++) begin
			addr_switch <= 5'(1 << i);
			repeat (4) @(posedge aclk);
			rdr(`SLP_STATUS_OFFSET);
			check(rd & 32'h0000_007c, 32'((i + 1) << 2), "stack address");
			check({31'h0, net_if_enable}, 32'h0000_0000, "net enable");
		end
		addr_switch <= 5'h03;
		repeat (4) @(posedge aclk);
		rdr(`SLP_STATUS_OFFSET);
		check(rd & 32'h0000_007c, 32'h0000_0020, "two switches");
		addr_switch <= 5'h00;
		sense <= 7'h00;
		repeat (4) @(posedge aclk);
		check({31'h0, net_if_enable}, 32'h0000_0000, "no interface fitted");
		sense <= 7'h01;
		repeat (4) @(posedge aclk);
		check({31'h0, net_if_enable}, 32'h0000_0001, "address zero");
		$display("t_addr done");
	endtask

	task automatic t_bad;
		wr(8'h08, 32'h0000_07ff);
		check(32'(rs), 32'(`SLP_RESP_SLVERR), "unmapped write");
		rdr(8'h0c);
		check(32'(rs), 32'(`SLP_RESP_SLVERR), "unmapped read");
		check(rd, 32'h0000_0000, "unmapped data");
		rdr(`SLP_CMD_OFFSET);
		check(rd, 32'h0000_03a0, "cmd kept");
		$display("t_bad done");
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_init;
		t_error;
		t_modes;
		t_chan;
		t_fault;
		t_addr;
		t_bad;
		end_sim;
	end
endmodule // tb_top

`default_nettype wire
